// ==== io_bank_defines.svh ====
// register offsets, field positions, reset values and timing counts of the io port bank
`ifndef IO_BANK_DEFINES_SVH
`define IO_BANK_DEFINES_SVH

// ==========================================================
// register word offsets (byte addresses)
`define ADDR_P0_LATCH 8'h00
`define ADDR_P0_CFG_A 8'h04
`define ADDR_P0_CFG_B 8'h08
`define ADDR_P1_LATCH 8'h0c
`define ADDR_P1_CFG_A 8'h10
`define ADDR_P1_CFG_B 8'h14
`define ADDR_P2_LATCH 8'h18
`define ADDR_P2_CFG_A 8'h1c
`define ADDR_P2_CFG_B 8'h20
`define ADDR_P3_LATCH 8'h24
`define ADDR_P3_CFG_A 8'h28
`define ADDR_P3_CFG_B 8'h2c
`define ADDR_P0_PIN 8'h30
`define ADDR_P1_PIN 8'h34
`define ADDR_P2_PIN 8'h38
`define ADDR_P3_PIN 8'h3c
`define ADDR_DIG_IN_DIS 8'h40
`define ADDR_USER_CFG1 8'h44
`define ADDR_PIN_COUNT 8'h48

// ==========================================================
// reset values: cfg a=1, b=0 selects input-only
`define RST_CFG_A 8'hff
`define RST_CFG_B 8'h00
`define RST_LATCH 8'hff
`define RST_DIG_IN_DIS 8'h00
`define RST_USER_CFG1 8'h00

// ==========================================================
// field positions
`define DIS_MASK 8'h3e
`define RST_PIN_EN_BIT 0
`define XTAL_BIT 1
`define EXTCLK_BIT 2
`define RST_PIN_POS 5
`define SCL_PIN_POS 2
`define SDA_PIN_POS 3

// ==========================================================
// pin counts per clock and reset option
`define PINS_RC_NORST 8'h1a
`define PINS_XTAL_RST 8'h17

// ==========================================================
// glitch filter settle count in cycles
`define FILTER_CYCLES 3

`endif

// ==== io_bank_pkg.sv ====
// types shared by the io port bank
`default_nettype none
package io_bank_pkg;
    // drive types, coded by cfg a/b bits
    typedef enum logic [1:0] {
        DRIVE_QUASI = 2'b00,
        DRIVE_PUSH_PULL = 2'b01,
        DRIVE_INPUT_ONLY = 2'b10,
        DRIVE_OPEN_DRAIN = 2'b11
    } drive_t;
endpackage
`default_nettype wire

// ==== pin_input_filter.sv ====
// input synchroniser plus hysteresis and glitch suppression for one pin
`timescale 1ns/100ps
`default_nettype none
`include "io_bank_defines.svh"
module pin_input_filter
    import io_bank_pkg::*;
#(
    parameter int FILTER_CYCLES = `FILTER_CYCLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // pin side
    input wire logic pin_i,
    // filtered level
    output logic level_o
);
    typedef struct packed {
        logic sync1;
        logic sync2;
        logic level;
        logic [3:0] count;
    } state_t;

    state_t state_reg;
    state_t state_next;

    // ==========================================================
    // level changes only after a stable run of samples
    always_comb begin
        state_next = state_reg;
        state_next.sync1 = pin_i;
        state_next.sync2 = state_reg.sync1;
        if (state_reg.sync2 == state_reg.level) begin
            state_next.count = 4'h0;
        end else if (state_reg.count == 4'(FILTER_CYCLES - 1)) begin
            state_next.level = state_reg.sync2;
            state_next.count = 4'h0;
        end else begin
            state_next.count = state_reg.count + 4'h1;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '{sync1: 1'b1, sync2: 1'b1, level: 1'b1, count: 4'h0};
        end else begin
            state_reg <= state_next;
        end
    end

    assign level_o = state_reg.level;
endmodule
`default_nettype wire

// ==== pin_driver.sv ====
// pin output driver for one pin: decodes the drive type into drive and enables
`timescale 1ns/100ps
`default_nettype none
module pin_driver
    import io_bank_pkg::*;
(
    // configuration
    input wire logic cfg_a_i,
    input wire logic cfg_b_i,
    input wire logic latch_i,
    input wire logic restricted_i,
    input wire logic input_only_i,
    // pad control
    output logic pin_o,
    output logic pin_oe_o,
    output logic weak_pullup_o
);
    drive_t drive;

    // restricted pins ignore quasi and push-pull codes
    always_comb begin
        drive = drive_t'({cfg_a_i, cfg_b_i});
        if (input_only_i) begin
            drive = DRIVE_INPUT_ONLY;
        end else if (restricted_i && !cfg_a_i) begin
            drive = DRIVE_INPUT_ONLY;
        end
        pin_o = latch_i;
        pin_oe_o = 1'b0;
        weak_pullup_o = 1'b0;
        unique case (drive)
            DRIVE_QUASI: begin
                pin_oe_o = !latch_i;
                weak_pullup_o = latch_i;
            end
            DRIVE_PUSH_PULL: begin
                pin_oe_o = 1'b1;
            end
            DRIVE_INPUT_ONLY: begin
                pin_oe_o = 1'b0;
            end
            DRIVE_OPEN_DRAIN: begin
                pin_o = 1'b0;
                pin_oe_o = !latch_i;
            end
        endcase
    end
endmodule
`default_nettype wire

// ==== configurable_io_port_bank.sv ====
// configurable io port bank: three 8-bit ports and one 2-bit port on wishbone
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "io_bank_defines.svh"
module configurable_io_port_bank
    import io_bank_pkg::*;
#(
    parameter int PORT_WIDTH = 8,
    parameter int PORT3_WIDTH = 2
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic err_o,
    // pins of ports zero to three
    input wire logic [PORT_WIDTH-1:0] p0_pin_i,
    input wire logic [PORT_WIDTH-1:0] p1_pin_i,
    input wire logic [PORT_WIDTH-1:0] p2_pin_i,
    input wire logic [PORT3_WIDTH-1:0] p3_pin_i,
    output logic [PORT_WIDTH-1:0] p0_pin_o,
    output logic [PORT_WIDTH-1:0] p1_pin_o,
    output logic [PORT_WIDTH-1:0] p2_pin_o,
    output logic [PORT3_WIDTH-1:0] p3_pin_o,
    output logic [PORT_WIDTH-1:0] p0_pin_oe_o,
    output logic [PORT_WIDTH-1:0] p1_pin_oe_o,
    output logic [PORT_WIDTH-1:0] p2_pin_oe_o,
    output logic [PORT3_WIDTH-1:0] p3_pin_oe_o,
    output logic [PORT_WIDTH-1:0] p0_weak_pullup_o,
    output logic [PORT_WIDTH-1:0] p1_weak_pullup_o,
    output logic [PORT_WIDTH-1:0] p2_weak_pullup_o,
    output logic [PORT3_WIDTH-1:0] p3_weak_pullup_o,
    // filtered inputs to internal logic
    output logic [PORT_WIDTH-1:0] p0_in_o,
    output logic [PORT_WIDTH-1:0] p1_in_o,
    output logic [PORT_WIDTH-1:0] p2_in_o,
    output logic [PORT3_WIDTH-1:0] p3_in_o,
    // reset pin request, active high
    output logic pin_reset_req_o
);
    localparam int NPINS = 3 * PORT_WIDTH + PORT3_WIDTH;
    localparam int P1_BASE = PORT_WIDTH;
    localparam int P2_BASE = 2 * PORT_WIDTH;
    localparam int P3_BASE = 3 * PORT_WIDTH;

    // all register state of the bank
    typedef struct packed {
        logic [PORT_WIDTH-1:0] p0_latch;
        logic [PORT_WIDTH-1:0] p1_latch;
        logic [PORT_WIDTH-1:0] p2_latch;
        logic [PORT3_WIDTH-1:0] p3_latch;
        logic [PORT_WIDTH-1:0] p0_cfg_a;
        logic [PORT_WIDTH-1:0] p0_cfg_b;
        logic [PORT_WIDTH-1:0] p1_cfg_a;
        logic [PORT_WIDTH-1:0] p1_cfg_b;
        logic [PORT_WIDTH-1:0] p2_cfg_a;
        logic [PORT_WIDTH-1:0] p2_cfg_b;
        logic [PORT3_WIDTH-1:0] p3_cfg_a;
        logic [PORT3_WIDTH-1:0] p3_cfg_b;
        logic [7:0] port0_digital_input_disable;
        logic [7:0] user_config_byte_one;
        logic ack;
        logic err;
        logic [31:0] rdata;
    } state_t;

    state_t state_reg;
    state_t state_next;

    logic [NPINS-1:0] pin_in;
    logic [NPINS-1:0] pin_out;
    logic [NPINS-1:0] pin_oe;
    logic [NPINS-1:0] pin_weak;
    logic [NPINS-1:0] filt;
    logic [NPINS-1:0] cfg_a_all;
    logic [NPINS-1:0] cfg_b_all;
    logic [NPINS-1:0] latch_all;
    logic [NPINS-1:0] restricted;
    logic [NPINS-1:0] input_only;
    logic [PORT_WIDTH-1:0] p0_masked;
    logic [7:0] pin_count;
    logic req;
    logic reset_pin_enable;

    // ==========================================================
    // flatten ports into one pin vector
    assign pin_in = {p3_pin_i, p2_pin_i, p1_pin_i, p0_pin_i};
    assign cfg_a_all = {state_reg.p3_cfg_a, state_reg.p2_cfg_a,
                        state_reg.p1_cfg_a, state_reg.p0_cfg_a};
    assign cfg_b_all = {state_reg.p3_cfg_b, state_reg.p2_cfg_b,
                        state_reg.p1_cfg_b, state_reg.p0_cfg_b};
    assign latch_all = {state_reg.p3_latch, state_reg.p2_latch,
                        state_reg.p1_latch, state_reg.p0_latch};

    // restricted and fixed-input pins of port one
    always_comb begin
        restricted = '0;
        input_only = '0;
        restricted[P1_BASE + `SCL_PIN_POS] = 1'b1;
        restricted[P1_BASE + `SDA_PIN_POS] = 1'b1;
        input_only[P1_BASE + `RST_PIN_POS] = 1'b1;
    end

    // ==========================================================
    // per-pin driver and input filter
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            pin_driver u_drv (
                .cfg_a_i(cfg_a_all[gi]),
                .cfg_b_i(cfg_b_all[gi]),
                .latch_i(latch_all[gi]),
                .restricted_i(restricted[gi]),
                .input_only_i(input_only[gi]),
                .pin_o(pin_out[gi]),
                .pin_oe_o(pin_oe[gi]),
                .weak_pullup_o(pin_weak[gi])
            );
            pin_input_filter u_filt (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(pin_in[gi]),
                .level_o(filt[gi])
            );
        end
    endgenerate

    // ==========================================================
    // pad outputs
    assign p0_pin_o = pin_out[P1_BASE-1:0];
    assign p1_pin_o = pin_out[P2_BASE-1:P1_BASE];
    assign p2_pin_o = pin_out[P3_BASE-1:P2_BASE];
    assign p3_pin_o = pin_out[NPINS-1:P3_BASE];
    assign p0_pin_oe_o = pin_oe[P1_BASE-1:0];
    assign p1_pin_oe_o = pin_oe[P2_BASE-1:P1_BASE];
    assign p2_pin_oe_o = pin_oe[P3_BASE-1:P2_BASE];
    assign p3_pin_oe_o = pin_oe[NPINS-1:P3_BASE];
    assign p0_weak_pullup_o = pin_weak[P1_BASE-1:0];
    assign p1_weak_pullup_o = pin_weak[P2_BASE-1:P1_BASE];
    assign p2_weak_pullup_o = pin_weak[P3_BASE-1:P2_BASE];
    assign p3_weak_pullup_o = pin_weak[NPINS-1:P3_BASE];

    // port zero inputs blocked where disabled
    assign p0_masked = filt[P1_BASE-1:0] &
                       ~state_reg.port0_digital_input_disable[PORT_WIDTH-1:0];
    assign p0_in_o = p0_masked;
    assign p1_in_o = filt[P2_BASE-1:P1_BASE];
    assign p2_in_o = filt[P3_BASE-1:P2_BASE];
    assign p3_in_o = filt[NPINS-1:P3_BASE];

    // reset pin: low-active reset only when enabled
    assign reset_pin_enable = state_reg.user_config_byte_one[`RST_PIN_EN_BIT];
    assign pin_reset_req_o = reset_pin_enable && !filt[P1_BASE + `RST_PIN_POS];

    // usable pin count from clock and reset options
    always_comb begin
        pin_count = `PINS_RC_NORST;
        if (state_reg.user_config_byte_one[`XTAL_BIT]) begin
            pin_count = pin_count - 8'h02;
        end else if (state_reg.user_config_byte_one[`EXTCLK_BIT]) begin
            pin_count = pin_count - 8'h01;
        end
        if (reset_pin_enable) begin
            pin_count = pin_count - 8'h01;
        end
    end

    // ==========================================================
    // wishbone slave: one wait-free ack, or err for an unmapped address, per request
    assign req = cyc_i && stb_i && !state_reg.ack && !state_reg.err;

    always_comb begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.err = 1'b0;
        if (req) begin
            state_next.ack = 1'b1;
            state_next.rdata = 32'h0000_0000;
            unique case (adr_i)
                `ADDR_P0_LATCH: state_next.rdata[PORT_WIDTH-1:0] = state_reg.p0_latch;
                `ADDR_P1_LATCH: state_next.rdata[PORT_WIDTH-1:0] = state_reg.p1_latch;
                `ADDR_P2_LATCH: state_next.rdata[PORT_WIDTH-1:0] = state_reg.p2_latch;
                `ADDR_P3_LATCH: state_next.rdata[PORT3_WIDTH-1:0] = state_reg.p3_latch;
                `ADDR_P0_CFG_A: state_next.rdata[PORT_WIDTH-1:0] = state_reg.p0_cfg_a;
                `ADDR_P0_CFG_B: state_next.rdata[PORT_WIDTH-1:0] = state_reg.p0_cfg_b;
                `ADDR_P1_CFG_A: state_next.rdata[PORT_WIDTH-1:0] = state_reg.p1_cfg_a;
                `ADDR_P1_CFG_B: state_next.rdata[PORT_WIDTH-1:0] = state_reg.p1_cfg_b;
                `ADDR_P2_CFG_A: state_next.rdata[PORT_WIDTH-1:0] = state_reg.p2_cfg_a;
                `ADDR_P2_CFG_B: state_next.rdata[PORT_WIDTH-1:0] = state_reg.p2_cfg_b;
                `ADDR_P3_CFG_A: state_next.rdata[PORT3_WIDTH-1:0] = state_reg.p3_cfg_a;
                `ADDR_P3_CFG_B: state_next.rdata[PORT3_WIDTH-1:0] = state_reg.p3_cfg_b;
                `ADDR_P0_PIN: state_next.rdata[PORT_WIDTH-1:0] = p0_masked;
                `ADDR_P1_PIN: state_next.rdata[PORT_WIDTH-1:0] = filt[P2_BASE-1:P1_BASE];
                `ADDR_P2_PIN: state_next.rdata[PORT_WIDTH-1:0] = filt[P3_BASE-1:P2_BASE];
                `ADDR_P3_PIN: state_next.rdata[PORT3_WIDTH-1:0] = filt[NPINS-1:P3_BASE];
                `ADDR_DIG_IN_DIS: state_next.rdata[7:0] = state_reg.port0_digital_input_disable;
                `ADDR_USER_CFG1: state_next.rdata[7:0] = state_reg.user_config_byte_one;
                `ADDR_PIN_COUNT: state_next.rdata[7:0] = pin_count;
                default: begin
                    state_next.ack = 1'b0;
                    state_next.err = 1'b1;
                end
            endcase
            // writes land on byte lane zero only
            if (we_i && sel_i[0]) begin
                unique case (adr_i)
                    `ADDR_P0_LATCH: state_next.p0_latch = dat_i[PORT_WIDTH-1:0];
                    `ADDR_P1_LATCH: state_next.p1_latch = dat_i[PORT_WIDTH-1:0];
                    `ADDR_P2_LATCH: state_next.p2_latch = dat_i[PORT_WIDTH-1:0];
                    `ADDR_P3_LATCH: state_next.p3_latch = dat_i[PORT3_WIDTH-1:0];
                    `ADDR_P0_CFG_A: state_next.p0_cfg_a = dat_i[PORT_WIDTH-1:0];
                    `ADDR_P0_CFG_B: state_next.p0_cfg_b = dat_i[PORT_WIDTH-1:0];
                    `ADDR_P1_CFG_A: state_next.p1_cfg_a = dat_i[PORT_WIDTH-1:0];
                    `ADDR_P1_CFG_B: state_next.p1_cfg_b = dat_i[PORT_WIDTH-1:0];
                    `ADDR_P2_CFG_A: state_next.p2_cfg_a = dat_i[PORT_WIDTH-1:0];
                    `ADDR_P2_CFG_B: state_next.p2_cfg_b = dat_i[PORT_WIDTH-1:0];
                    `ADDR_P3_CFG_A: state_next.p3_cfg_a = dat_i[PORT3_WIDTH-1:0];
                    `ADDR_P3_CFG_B: state_next.p3_cfg_b = dat_i[PORT3_WIDTH-1:0];
                    `ADDR_DIG_IN_DIS: begin
                        state_next.port0_digital_input_disable = dat_i[7:0] & `DIS_MASK;
                    end
                    `ADDR_USER_CFG1: state_next.user_config_byte_one = dat_i[7:0];
                    default: begin
                    end
                endcase
            end
        end
    end

    // state register; reset puts every pin in input-only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.p0_latch <= `RST_LATCH;
            state_reg.p1_latch <= `RST_LATCH;
            state_reg.p2_latch <= `RST_LATCH;
            state_reg.p3_latch <= PORT3_WIDTH'(`RST_LATCH);
            state_reg.p0_cfg_a <= `RST_CFG_A;
            state_reg.p1_cfg_a <= `RST_CFG_A;
            state_reg.p2_cfg_a <= `RST_CFG_A;
            state_reg.p3_cfg_a <= PORT3_WIDTH'(`RST_CFG_A);
            state_reg.p0_cfg_b <= `RST_CFG_B;
            state_reg.p1_cfg_b <= `RST_CFG_B;
            state_reg.p2_cfg_b <= `RST_CFG_B;
            state_reg.p3_cfg_b <= PORT3_WIDTH'(`RST_CFG_B);
            state_reg.port0_digital_input_disable <= `RST_DIG_IN_DIS;
            state_reg.user_config_byte_one <= `RST_USER_CFG1;
        end else begin
            state_reg <= state_next;
        end
    end

    // bus outputs from flip-flops
    assign dat_o = state_reg.rdata;
    assign ack_o = state_reg.ack;
    assign err_o = state_reg.err;
endmodule
`default_nettype wire

// ==== io_bank_asserts.sv ====
// concurrent checks on the io port bank pins and bus answer
`timescale 1ns/100ps
`default_nettype none
module io_bank_asserts import io_bank_pkg::*; #(
    parameter int PORT_WIDTH = 8,
    parameter int PORT3_WIDTH = 2
) (
    // clock, reset and bus answer
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic ack_o,
    input wire logic err_o,
    // pads and filtered inputs
    input wire logic [PORT_WIDTH-1:0] p0_pin_oe_o,
    input wire logic [PORT_WIDTH-1:0] p0_weak_pullup_o,
    input wire logic [PORT_WIDTH-1:0] p1_pin_o,
    input wire logic [PORT_WIDTH-1:0] p1_pin_oe_o,
    input wire logic [PORT_WIDTH-1:0] p1_weak_pullup_o,
    input wire logic [PORT_WIDTH-1:0] p1_in_o,
    input wire logic [PORT3_WIDTH-1:0] p3_pin_i,
    input wire logic [PORT3_WIDTH-1:0] p3_in_o,
    input wire logic pin_reset_req_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // =====
    // properties
    chk_bus_answer: assert property ((cyc_i && stb_i && !ack_o && !err_o) |=>
        (ack_o ^ err_o))
        else $error("request not answered next cycle");
    chk_answer_single: assert property ((ack_o || err_o) |=> !(ack_o || err_o))
        else $error("answer longer than one cycle");
    chk_rst_pin_input: assert property (!p1_pin_oe_o[5] && !p1_weak_pullup_o[5])
        else $error("reset-shared pin driven");
    chk_shared_od_only: assert property (p1_weak_pullup_o[3:2] == 2'b00 &&
        (p1_pin_oe_o[3:2] & p1_pin_o[3:2]) == 2'b00)
        else $error("shared pin drives high");
    chk_weak_not_strong: assert property ((p0_weak_pullup_o & p0_pin_oe_o) == '0)
        else $error("weak and strong drive together");
    chk_reset_idle: assert property (@(posedge clk_i) disable iff (1'b0) $fell(rst_i) |->
        (p0_pin_oe_o == '0 && p1_pin_oe_o == '0 && p0_weak_pullup_o == '0))
        else $error("pins driven after reset");
    chk_filter_calm: assert property (((p3_in_o ^ $past(p3_in_o)) & (
        $past(p3_pin_i, 3) ^ $past(p3_pin_i, 4) |
        $past(p3_pin_i, 4) ^ $past(p3_pin_i, 5))) == '0)
        else $error("input moved before pin settled");
    chk_reset_request: assert property (pin_reset_req_o |-> !p1_in_o[5])
        else $error("reset request with pin high");
    cover property (err_o);
    cover property (pin_reset_req_o);
    cover property ($changed(p3_in_o));
endmodule
bind configurable_io_port_bank io_bank_asserts
    #(.PORT_WIDTH(PORT_WIDTH), .PORT3_WIDTH(PORT3_WIDTH))
    u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .err_o(err_o), .p0_pin_oe_o(p0_pin_oe_o), .p0_weak_pullup_o(p0_weak_pullup_o),
    .p1_pin_o(p1_pin_o), .p1_pin_oe_o(p1_pin_oe_o), .p1_weak_pullup_o(p1_weak_pullup_o),
    .p1_in_o(p1_in_o), .p3_pin_i(p3_pin_i), .p3_in_o(p3_in_o), .pin_reset_req_o(pin_reset_req_o));
`default_nettype wire

// ==== board_model.sv ====
// board circuitry: resolves each pin wire from bank and board drivers
`timescale 1ns/100ps
`default_nettype none
module board_model import io_bank_pkg::*; #(
    parameter int W = 26
) (
    // clock for the floating pattern
    input wire logic clk_i,
    // bank side
    input wire logic [W-1:0] pin_i,
    input wire logic [W-1:0] oe_i,
    input wire logic [W-1:0] weak_i,
    // board side
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_val_i,
    input wire logic [W-1:0] pullup_i,
    // resolved level
    output logic [W-1:0] level_o
);
    // undriven lines wander every cycle
    logic [W-1:0] float_reg = '0;
    always @(posedge clk_i) begin
        float_reg <= ~float_reg;
    end
    // strong drive, board drive over weak, pull-ups, else floating
    always_comb begin
        level_o = (oe_i & pin_i) | (~oe_i & ext_en_i & ext_val_i);
        level_o = level_o | (~oe_i & ~ext_en_i & (weak_i | pullup_i));
        level_o = level_o | (~oe_i & ~ext_en_i & ~weak_i & ~pullup_i & float_reg);
    end
endmodule
`default_nettype wire

// ==== test_configurable_io_port_bank.sv ====
// self-checking bench of the io port bank with a board model on the pins
`timescale 1ns/100ps
`default_nettype none
`include "io_bank_defines.svh"
module test_configurable_io_port_bank import io_bank_pkg::*; ;
    typedef struct packed {
        logic [7:0] p, a, b, l, oe, o, wk;
    } row_t;
    // port, cfg a, cfg b, latch, expected enable, drive, weak
    row_t rows [8] = '{'{8'h00, 8'h00, 8'h00, 8'hf0, 8'h0f, 8'h00, 8'hf0},
        '{8'h00, 8'h00, 8'hff, 8'ha5, 8'hff, 8'ha5, 8'h00},
        '{8'h02, 8'hff, 8'hff, 8'h3c, 8'hc3, 8'h00, 8'h00},
        '{8'h02, 8'hff, 8'h00, 8'h3c, 8'h00, 8'h00, 8'h00},
        '{8'h01, 8'h00, 8'h00, 8'h00, 8'hd3, 8'h00, 8'h00},
        '{8'h01, 8'h00, 8'hff, 8'hff, 8'hd3, 8'hd3, 8'h00},
        '{8'h01, 8'hff, 8'hff, 8'h00, 8'hdf, 8'h00, 8'h00},
        '{8'h03, 8'h00, 8'h01, 8'h02, 8'h01, 8'h00, 8'h02}};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0;
    logic stb_i = 1'b0;
    logic we_i = 1'b0;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic ack_o, err_o, pin_reset_req_o, e;
    logic [7:0] rd;
    wire logic [25:0] po, oe, wk, lvl, in_all;
    logic [25:0] ext_en = '0;
    logic [25:0] ext_val = '0;
    logic [25:0] pu = '0;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    configurable_io_port_bank dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .err_o(err_o), .pin_reset_req_o(pin_reset_req_o), .p0_pin_i(lvl[7:0]),
        .p1_pin_i(lvl[15:8]), .p2_pin_i(lvl[23:16]), .p3_pin_i(lvl[25:24]),
        .p0_pin_o(po[7:0]), .p1_pin_o(po[15:8]), .p2_pin_o(po[23:16]), .p3_pin_o(po[25:24]),
        .p0_pin_oe_o(oe[7:0]), .p1_pin_oe_o(oe[15:8]), .p2_pin_oe_o(oe[23:16]),
        .p3_pin_oe_o(oe[25:24]), .p0_weak_pullup_o(wk[7:0]), .p1_weak_pullup_o(wk[15:8]),
        .p2_weak_pullup_o(wk[23:16]), .p3_weak_pullup_o(wk[25:24]), .p0_in_o(in_all[7:0]),
        .p1_in_o(in_all[15:8]), .p2_in_o(in_all[23:16]), .p3_in_o(in_all[25:24]));
    board_model #(.W(26)) u_board (.clk_i(clk_i), .pin_i(po), .oe_i(oe), .weak_i(wk),
        .ext_en_i(ext_en), .ext_val_i(ext_val), .pullup_i(pu), .level_o(lvl));
    // =====
    // clock, timeout and helpers
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("[FAIL] %0t run timed out", $time);
            finish_test();
        end
    end
    task automatic finish_test();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // one classic cycle, held until ack or err is sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 40);
        if (n >= 40) chk(8'h00, 8'h01, "bus unanswered");
        rd = dat_o[7:0];
        e = err_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
    endtask
    task automatic drive_board(input logic [25:0] en, input logic [25:0] val,
        input logic [25:0] pull);
        @(posedge clk_i);
        ext_en <= en;
        ext_val <= val;
        pu <= pull;
    endtask
    task automatic do_reset();
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_cyc(1);
    endtask
    function automatic logic [7:0] sel8(input logic [25:0] v, input logic [7:0] p);
        return 8'(v >> (8 * p));
    endfunction
    // =====
    // main sequence
    initial begin
        do_reset();
        chk({7'h0, |(oe | wk)}, 8'h00, "drive after reset");
        bus(1'b0, `ADDR_P0_CFG_A, 8'h00);
        chk(rd, 8'hff, "cfg a reset");
        bus(1'b0, `ADDR_P3_CFG_B, 8'h00);
        chk(rd, 8'h00, "cfg b reset");
        bus(1'b0, `ADDR_PIN_COUNT, 8'h00);
        chk(rd, 8'h1a, "pins rc no reset");
        foreach (rows[i]) begin
            bus(1'b1, 8'(12 * rows[i].p), rows[i].l);
            bus(1'b1, 8'(12 * rows[i].p + 4), rows[i].a);
            bus(1'b1, 8'(12 * rows[i].p + 8), rows[i].b);
            wait_cyc(12);
            chk(sel8(oe, rows[i].p), rows[i].oe, "enable");
            chk(sel8(po & oe, rows[i].p), rows[i].o, "drive");
            chk(sel8(wk, rows[i].p), rows[i].wk, "weak");
            chk(sel8(in_all & (oe | wk), rows[i].p), rows[i].o | rows[i].wk, "input");
            bus(1'b0, 8'(12 * rows[i].p), 8'h00);
            chk(rd, rows[i].l, "latch readback");
        end
        bus(1'b1, 8'h4c, 8'h5a);
        chk({7'h0, e}, 8'h01, "unmapped");
        bus(1'b1, `ADDR_USER_CFG1, 8'h04);
        bus(1'b0, `ADDR_PIN_COUNT, 8'h00);
        chk(rd, 8'h19, "pins external clock");
        bus(1'b1, `ADDR_USER_CFG1, 8'h03);
        bus(1'b1, `ADDR_PIN_COUNT, 8'h00);
        bus(1'b0, `ADDR_PIN_COUNT, 8'h00);
        chk(rd, 8'h17, "pins crystal reset");
        drive_board(26'h0002000, 26'h0, 26'h0);
        wait_cyc(12);
        chk({7'h0, pin_reset_req_o}, 8'h01, "reset request");
        drive_board(26'h0002000, 26'h0002000, 26'h0);
        wait_cyc(12);
        chk({7'h0, pin_reset_req_o}, 8'h00, "reset released");
        drive_board(26'h0002000, 26'h0, 26'h0);
        bus(1'b1, `ADDR_USER_CFG1, 8'h00);
        wait_cyc(12);
        chk({6'h0, pin_reset_req_o, in_all[13]}, 8'h00, "plain input");
        // port zero input disable, then a reset in mid-run
        bus(1'b1, `ADDR_P0_CFG_A, 8'hff);
        bus(1'b1, `ADDR_P0_CFG_B, 8'h00);
        drive_board(26'h0002000, 26'h0, 26'h00000ff);
        bus(1'b1, `ADDR_DIG_IN_DIS, 8'hff);
        bus(1'b0, `ADDR_DIG_IN_DIS, 8'h00);
        chk(rd, 8'h3e, "disable bits");
        wait_cyc(12);
        chk(in_all[7:0], 8'hc1, "disabled inputs");
        do_reset();
        bus(1'b0, `ADDR_DIG_IN_DIS, 8'h00);
        chk(rd, 8'h00, "disable after reset");
        chk({7'h0, |(oe | wk)}, 8'h00, "drive after second reset");
        // one-cycle glitch on port two must not pass
        drive_board(26'h0ff0000, 26'h0, 26'h0);
        wait_cyc(12);
        drive_board(26'h0ff0000, 26'h0ff0000, 26'h0);
        drive_board(26'h0ff0000, 26'h0, 26'h0);
        repeat (8) begin
            wait_cyc(1);
            chk(in_all[23:16], 8'h00, "glitch blocked");
        end
        // open drain against a board pull-up
        bus(1'b1, `ADDR_P2_CFG_B, 8'hff);
        drive_board(26'h0, 26'h0, 26'h0ff0000);
        wait_cyc(12);
        chk(in_all[23:16], 8'hff, "released high");
        bus(1'b0, `ADDR_P2_PIN, 8'h00);
        chk(rd, 8'hff, "pin read");
        bus(1'b1, `ADDR_P2_LATCH, 8'h00);
        wait_cyc(12);
        chk(in_all[23:16], 8'h00, "pulled low");
        finish_test();
    end
endmodule
`default_nettype wire
